// [rtl/pll_ctrl_pkg.sv]
// Shared constants, register map and types for the clock-synthesis control block.
// Assumes a single pclk domain and an APB register bus.
package pll_ctrl_pkg;

   // ------------------------------------------------------------------
   // Register offsets (byte addresses)
   // ------------------------------------------------------------------
   localparam logic [7:0] OFF_CTRL    = 8'h00;
   localparam logic [7:0] OFF_DIVSET  = 8'h04;
   localparam logic [7:0] OFF_LOCKCNT = 8'h08;
   localparam logic [7:0] OFF_SKEW    = 8'h0C;
   localparam logic [7:0] OFF_ROUTE   = 8'h10;
   localparam logic [7:0] OFF_STATUS  = 8'h14;
   localparam logic [7:0] OFF_IRQ_ST  = 8'h18;
   localparam logic [7:0] OFF_IRQ_MSK = 8'h1C;

   // ------------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------------
   localparam int CTRL_DIFF_BIT   = 0;
   localparam int CTRL_EXTFB_BIT  = 1;
   localparam int CTRL_FBSEL_LSB  = 4;
   localparam int DIV_FIELD_W     = 5;
   localparam int DIV0_LSB        = 0;
   localparam int DIV1_LSB        = 8;
   localparam int DIV2_LSB        = 16;
   localparam int SKEW_FIELD_W    = 3;
   localparam int IRQ_LOCK_BIT    = 0;
   localparam int IRQ_UNLOCK_BIT  = 1;

   // ------------------------------------------------------------------
   // Reset values and limits
   // ------------------------------------------------------------------
   localparam logic [31:0] CTRL_RST    = 32'h0000_0000;
   localparam logic [31:0] DIVSET_RST  = 32'h0001_0101;
   localparam logic [8:0]  LOCKCNT_RST = 9'h010;
   localparam logic [8:0]  LOCKCNT_MIN = 9'h010;
   localparam logic [8:0]  LOCKCNT_MAX = 9'h100;
   localparam logic [4:0]  DIV_ONE     = 5'h01;

   // Routing source codes for each output pin
   typedef enum logic [2:0] {
      SRC_DIV0, SRC_DIV1, SRC_DIV2, SRC_REF_SEL, SRC_REF_OTHER, SRC_OFF
   } route_src_t;

   typedef struct packed {
      logic ref_single_first;
      logic ref_single_second;
      logic ref_diff_pos;
      logic ref_diff_neg;
   } ref_pins_t;

endpackage

// [rtl/pow2_divider.sv]
// Power-of-two output divider driven by an oscillator-rate enable.
// Assumes the source clock arrives as a sampled level in pclk.
`timescale 1ns/1ps
module pow2_divider (
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic       src,
   input  wire logic [4:0] ratio,
   output logic            div_out
);
   logic [4:0] cnt_r, cnt_nxt;
   logic       src_d_r;
   logic       out_r, out_nxt;
   logic       rise;
   logic [5:0] ratio_full;

   assign rise = src & ~src_d_r;
   // Code zero selects ratio 32, the one value a 5-bit one-hot misses
   assign ratio_full = (ratio == 5'h00) ? 6'h20 : {1'b0, ratio};

   // ------------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------------
   always_comb begin
      cnt_nxt = cnt_r;
      out_nxt = out_r;
      if (ratio == 5'h01) begin
         out_nxt = src;
         cnt_nxt = 5'h00;
      end else if (rise) begin
         // Toggle every ratio/2 source edges
         if ({1'b0, cnt_r} >= (ratio_full >> 1) - 6'h01) begin
            cnt_nxt = 5'h00;
            out_nxt = ~out_r;
         end else begin
            cnt_nxt = cnt_r + 5'h01;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_r   <= 5'h00;
         out_r   <= 1'b0;
         src_d_r <= 1'b0;
      end else begin
         cnt_r   <= cnt_nxt;
         out_r   <= out_nxt;
         src_d_r <= src;
      end
   end

   assign div_out = out_r;
endmodule // pow2_divider

// [rtl/pll_divider_refselect_lock.sv]
// Digital control around the clock-synthesis loop: reference choice,
// three power-of-two dividers, bypass, lock detect, skew and routing.
// Assumes pins are asynchronous; oscillator is sampled as a level in pclk.
//
// Decided for this implementation: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps

module pll_divider_refselect_lock
   import pll_ctrl_pkg::*;
#(
   parameter int N_OUT = 4
) (
   input  wire logic                      pclk,
   input  wire logic                      presetn,
   input  wire logic                      psel,
   input  wire logic                      penable,
   input  wire logic                      pwrite,
   input  wire logic [7:0]                paddr,
   input  wire logic [31:0]               pwdata,
   output logic      [31:0]               prdata,
   output logic                           pready,
   output logic                           pslverr,
   input  wire pll_ctrl_pkg::ref_pins_t   ref_pins,
   input  wire logic                      ref_input_choose,
   input  wire logic                      bypass_pin,
   input  wire logic                      vco_clk,
   input  wire logic                      phase_freq_compare,
   input  wire logic                      ext_fb_in,
   output logic                           fb_to_compare,
   output logic                           lock,
   output logic      [N_OUT-1:0]          clk_out,
   output logic                           irq
);
   import pll_ctrl_pkg::*;

   if (N_OUT < 1 || N_OUT > 8) begin : g_bad_n_out
      $error("N_OUT must be 1..8");
   end

   // ------------------------------------------------------------------
   // Pin synchronisers
   // ------------------------------------------------------------------
   localparam int NS = 8;
   logic [NS-1:0] s1_r, s2_r;
   logic [NS-1:0] pins_in;
   assign pins_in = {ref_pins, ref_input_choose, bypass_pin, vco_clk, phase_freq_compare};

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s1_r <= '0;
         s2_r <= '0;
      end else begin
         s1_r <= pins_in;
         s2_r <= s1_r;
      end
   end

   logic ra, rb, rp, rn, choose, bypass, vco, in_lock;
   logic ext_fb_s1_r, ext_fb_r;
   assign {ra, rb, rp, rn, choose, bypass, vco, in_lock} = s2_r;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ext_fb_s1_r <= 1'b0;
         ext_fb_r    <= 1'b0;
      end else begin
         ext_fb_s1_r <= ext_fb_in;
         ext_fb_r    <= ext_fb_s1_r;
      end
   end

   // ------------------------------------------------------------------
   // Register file
   // ------------------------------------------------------------------
   logic [31:0] ctrl_r, ctrl_nxt;
   logic [31:0] div_r, div_nxt;
   logic [8:0]  lockcnt_r, lockcnt_nxt;
   logic [31:0] skew_r, skew_nxt;
   logic [31:0] route_r, route_nxt;
   logic [1:0]  irq_st_r, irq_st_nxt;
   logic [1:0]  irq_msk_r, irq_msk_nxt;
   logic        wr_en, rd_en;
   logic        lock_rise, lock_fall;

   // Legal settings: one-hot ratios 1..16, zero for 32
   function automatic logic div_legal(input logic [4:0] v);
      return (v & (v - 5'h01)) == 5'h00;
   endfunction

   function automatic logic [4:0] div_field(input logic [31:0] w, input int lsb);
      return w[lsb +: DIV_FIELD_W];
   endfunction

   assign wr_en   = psel & penable & pwrite;
   assign rd_en   = psel & ~pwrite;
   assign pready  = 1'b1;

   always_comb begin
      pslverr = 1'b0;
      if (psel && penable) begin
         case (paddr)
            OFF_CTRL, OFF_DIVSET, OFF_LOCKCNT, OFF_SKEW, OFF_ROUTE,
            OFF_STATUS, OFF_IRQ_ST, OFF_IRQ_MSK: pslverr = 1'b0;
            default: pslverr = 1'b1;
         endcase
      end
   end

   always_comb begin
      ctrl_nxt    = ctrl_r;
      div_nxt     = div_r;
      lockcnt_nxt = lockcnt_r;
      skew_nxt    = skew_r;
      route_nxt   = route_r;
      irq_msk_nxt = irq_msk_r;
      irq_st_nxt  = irq_st_r;
      if (wr_en) begin
         case (paddr)
            OFF_CTRL: ctrl_nxt = pwdata & 32'h0000_0033;
            OFF_DIVSET: begin
               // Illegal ratios are ignored field by field
               if (div_legal(div_field(pwdata, DIV0_LSB)))
                  div_nxt[DIV0_LSB +: DIV_FIELD_W] = div_field(pwdata, DIV0_LSB);
               if (div_legal(div_field(pwdata, DIV1_LSB)))
                  div_nxt[DIV1_LSB +: DIV_FIELD_W] = div_field(pwdata, DIV1_LSB);
               if (div_legal(div_field(pwdata, DIV2_LSB)))
                  div_nxt[DIV2_LSB +: DIV_FIELD_W] = div_field(pwdata, DIV2_LSB);
            end
            OFF_LOCKCNT: begin
               // Out-of-range counts clamp
               if (pwdata[8:0] < LOCKCNT_MIN)
                  lockcnt_nxt = LOCKCNT_MIN;
               else if (pwdata > 32'(LOCKCNT_MAX))
                  lockcnt_nxt = LOCKCNT_MAX;
               else
                  lockcnt_nxt = pwdata[8:0];
            end
            OFF_SKEW:    skew_nxt    = pwdata;
            OFF_ROUTE:   route_nxt   = pwdata;
            OFF_IRQ_MSK: irq_msk_nxt = pwdata[1:0];
            OFF_IRQ_ST:  irq_st_nxt  = irq_st_r & ~pwdata[1:0];
            default: ;
         endcase
      end
      // Set wins over a same-cycle clear
      if (lock_rise) irq_st_nxt[IRQ_LOCK_BIT] = 1'b1;
      if (lock_fall) irq_st_nxt[IRQ_UNLOCK_BIT] = 1'b1;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_r    <= CTRL_RST;
         div_r     <= DIVSET_RST;
         lockcnt_r <= LOCKCNT_RST;
         skew_r    <= 32'h0000_0000;
         route_r   <= 32'h0000_0000;
         irq_st_r  <= 2'h0;
         irq_msk_r <= 2'h0;
      end else begin
         ctrl_r    <= ctrl_nxt;
         div_r     <= div_nxt;
         lockcnt_r <= lockcnt_nxt;
         skew_r    <= skew_nxt;
         route_r   <= route_nxt;
         irq_st_r  <= irq_st_nxt;
         irq_msk_r <= irq_msk_nxt;
      end
   end

   logic diff_mode, ext_fb;
   logic [1:0] fb_sel;
   assign diff_mode = ctrl_r[CTRL_DIFF_BIT];
   assign ext_fb    = ctrl_r[CTRL_EXTFB_BIT];
   assign fb_sel    = ctrl_r[CTRL_FBSEL_LSB +: 2];

   // ------------------------------------------------------------------
   // Reference selection
   // ------------------------------------------------------------------
   logic ref_sel, ref_other;
   always_comb begin
      if (diff_mode) begin
         // Select pin is assumed held low by the board here
         ref_sel   = rp & ~rn;
         ref_other = 1'b0;
      end else begin
         ref_sel   = choose ? rb : ra;
         ref_other = choose ? ra : rb;
      end
   end

   // ------------------------------------------------------------------
   // Dividers
   // ------------------------------------------------------------------
   logic       div_src;
   logic [2:0] div_raw;
   logic [2:0] div_o;
   assign div_src = bypass ? ref_sel : vco;

   for (genvar k = 0; k < 3; k++) begin : g_div
      pow2_divider u_div (
         .pclk    (pclk),
         .presetn (presetn),
         .src     (div_src),
         .ratio   (div_r[k*8 +: DIV_FIELD_W]),
         .div_out (div_raw[k])
      );
      // Ratio 1 in bypass passes the reference inverted
      assign div_o[k] = (bypass && div_r[k*8 +: DIV_FIELD_W] == DIV_ONE)
                        ? ~div_raw[k] : div_raw[k];
   end

   // Feedback: internal divider or an external pin
   always_comb begin
      case (fb_sel)
         2'd0:    fb_to_compare = ext_fb ? ext_fb_r : div_o[0];
         2'd1:    fb_to_compare = ext_fb ? ext_fb_r : div_o[1];
         2'd2:    fb_to_compare = ext_fb ? ext_fb_r : div_o[2];
         default: fb_to_compare = ext_fb ? ext_fb_r : div_o[0];
      endcase
   end

   // ------------------------------------------------------------------
   // Lock detect
   // ------------------------------------------------------------------
   typedef enum {LK_IDLE, LK_COUNT, LK_LOCKED} lk_state_t;
   lk_state_t  lk_r, lk_nxt;
   logic [8:0] lkcnt_r, lkcnt_nxt;
   logic       ref_d_r, ref_edge;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) ref_d_r <= 1'b0;
      else          ref_d_r <= ref_sel;
   end
   assign ref_edge = ref_sel & ~ref_d_r;

   always_comb begin
      lk_nxt    = lk_r;
      lkcnt_nxt = lkcnt_r;
      case (lk_r)
         LK_IDLE: begin
            lkcnt_nxt = 9'h000;
            if (in_lock && !bypass) lk_nxt = LK_COUNT;
         end
         LK_COUNT: begin
            if (!in_lock || bypass) begin
               lk_nxt    = LK_IDLE;
               lkcnt_nxt = 9'h000;
            end else if (ref_edge) begin
               lkcnt_nxt = lkcnt_r + 9'h001;
               if (lkcnt_r + 9'h001 >= lockcnt_r) lk_nxt = LK_LOCKED;
            end
         end
         LK_LOCKED: begin
            if (!in_lock || bypass) begin
               lk_nxt    = LK_IDLE;
               lkcnt_nxt = 9'h000;
            end
         end
         default: lk_nxt = LK_IDLE;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lk_r    <= LK_IDLE;
         lkcnt_r <= 9'h000;
      end else begin
         lk_r    <= lk_nxt;
         lkcnt_r <= lkcnt_nxt;
      end
   end

   // Gated by live condition so loss drops the output the same cycle
   assign lock = (lk_r == LK_LOCKED) && in_lock && !bypass;

   logic lock_d_r;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) lock_d_r <= 1'b0;
      else          lock_d_r <= lock;
   end
   assign lock_rise = lock & ~lock_d_r;
   assign lock_fall = ~lock & lock_d_r;
   assign irq = |(irq_st_r & irq_msk_r);

   // ------------------------------------------------------------------
   // Skew: delay line clocked by oscillator edges
   // ------------------------------------------------------------------
   // Steps are whole oscillator periods, no analog delay element
   logic [2:0] dly_r [3][8];
   logic [2:0] dly_nxt [3][8];
   logic       vco_d_r, vco_edge;
   logic [2:0] skewed;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) vco_d_r <= 1'b0;
      else          vco_d_r <= vco;
   end
   assign vco_edge = vco & ~vco_d_r;

   always_comb begin
      dly_nxt = dly_r;
      for (int k = 0; k < 3; k++) begin
         if (vco_edge) begin
            dly_nxt[k][0] = {2'b00, div_o[k]};
            for (int j = 1; j < 8; j++) dly_nxt[k][j] = dly_r[k][j-1];
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int k = 0; k < 3; k++)
            for (int j = 0; j < 8; j++) dly_r[k][j] <= 3'h0;
      end else begin
         dly_r <= dly_nxt;
      end
   end

   always_comb begin
      for (int k = 0; k < 3; k++) begin
         // Bypass skips skew entirely
         if (bypass || skew_r[k*4 +: SKEW_FIELD_W] == 3'h0)
            skewed[k] = div_o[k];
         else
            skewed[k] = dly_r[k][skew_r[k*4 +: SKEW_FIELD_W] - 3'h1][0];
      end
   end

   // ------------------------------------------------------------------
   // Output routing matrix
   // ------------------------------------------------------------------
   logic [N_OUT-1:0] out_nxt, out_r;
   always_comb begin
      for (int i = 0; i < N_OUT; i++) begin
         case (route_src_t'(route_r[i*4 +: 3]))
            SRC_DIV0:      out_nxt[i] = skewed[0];
            SRC_DIV1:      out_nxt[i] = skewed[1];
            SRC_DIV2:      out_nxt[i] = skewed[2];
            SRC_REF_SEL:   out_nxt[i] = diff_mode ? 1'b0 : ref_sel;
            SRC_REF_OTHER: out_nxt[i] = diff_mode ? 1'b0 : ref_other;
            default:       out_nxt[i] = 1'b0;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) out_r <= '0;
      else          out_r <= out_nxt;
   end
   assign clk_out = out_r;

   // ------------------------------------------------------------------
   // Read mux
   // ------------------------------------------------------------------
   always_comb begin
      prdata = 32'h0000_0000;
      if (rd_en) begin
         case (paddr)
            OFF_CTRL:    prdata = ctrl_r;
            OFF_DIVSET:  prdata = div_r;
            OFF_LOCKCNT: prdata = {23'h0, lockcnt_r};
            OFF_SKEW:    prdata = skew_r;
            OFF_ROUTE:   prdata = route_r;
            OFF_STATUS:  prdata = {28'h0, bypass, in_lock, lk_r == LK_COUNT, lock};
            OFF_IRQ_ST:  prdata = {30'h0, irq_st_r};
            OFF_IRQ_MSK: prdata = {30'h0, irq_msk_r};
            default:     prdata = 32'h0000_0000;
         endcase
      end
   end
endmodule // pll_divider_refselect_lock

// [dv/pll_lock_apb_properties.sv]
// Checker for the clock control block: APB answer and lock indicator.
// Sees only top-level ports; bound into every instance of the block.
`timescale 1ns/1ps
module pll_lock_apb_properties (
   input wire logic       pclk,
   input wire logic       presetn,
   input wire logic       psel,
   input wire logic       penable,
   input wire logic [7:0] paddr,
   input wire logic       pready,
   input wire logic       pslverr,
   input wire logic       phase_freq_compare,
   input wire logic       bypass_pin,
   input wire logic       lock
);
   logic [7:0] run_r;
   logic [7:0] run_nxt;

   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);

   // Cycles of loop lock outside bypass; saturates
   always_comb begin
      run_nxt = (!phase_freq_compare || bypass_pin) ? 8'h00 :
                (run_r == 8'hFF) ? run_r : run_r + 8'h01;
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         run_r <= 8'h00;
      else
         run_r <= run_nxt;
   end

   // 16 edges of a synced reference span at least 30 cycles
   a_lock_after_count: assert property ($rose(lock) |-> run_r >= 8'h1E)
      else $error("lock rose too early");
   a_relock_full: assert property ($fell(lock) |-> (!lock)[*8])
      else $error("lock came back at once");
   a_lock_hold: assert property (lock && run_r >= 8'h04 |=> lock)
      else $error("lock dropped while locked");
   a_loss_drop: assert property ((!phase_freq_compare)[*3] |-> !lock)
      else $error("lock held after loss");
   a_bypass_drop: assert property (bypass_pin[*3] |-> !lock)
      else $error("lock held in bypass");
   a_ready_high: assert property (psel |-> pready)
      else $error("pready low");
   a_err_unmapped: assert property (psel && penable && paddr > 8'h1C |-> pslverr)
      else $error("no error on unmapped address");
   a_err_mapped: assert property (psel && penable && paddr <= 8'h1C
                                  && paddr[1:0] == 2'b00 |-> !pslverr)
      else $error("error on mapped address");
   a_err_idle: assert property (!(psel && penable) |-> !pslverr)
      else $error("error outside access");

   cover property ($rose(lock));
   cover property ($fell(lock) && bypass_pin);
   cover property (psel && penable && pslverr);
endmodule // pll_lock_apb_properties

bind pll_divider_refselect_lock pll_lock_apb_properties chk_u (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .paddr(paddr),
   .pready(pready), .pslverr(pslverr), .phase_freq_compare(phase_freq_compare),
   .bypass_pin(bypass_pin), .lock(lock));

// [dv/ref_src_model.sv]
// Far-side model: reference clocks, oscillator and loop lock level.
// Assumes the bench clock; outputs change just after pclk rises.
`timescale 1ns/1ps
module ref_src_model
   import pll_ctrl_pkg::*;
(
   input  wire logic               pclk,
   input  wire logic               presetn,
   input  wire logic               in_lock_req,
   input  wire logic               slow,
   output pll_ctrl_pkg::ref_pins_t ref_pins,
   output logic                    vco_clk,
   output logic                    phase_freq_compare
);
   logic [3:0] div_r;
   logic [3:0] div_nxt;
   logic [7:0] lag_r;
   logic [7:0] lag_nxt;

   always_comb begin
      div_nxt = div_r + 4'h1;
      lag_nxt = {lag_r[6:0], in_lock_req};
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_r <= 4'h0;
         lag_r <= 8'h00;
      end else begin
         div_r <= div_nxt;
         lag_r <= lag_nxt;
      end
   end
   // First reference period 8, second 16; pair complementary
   assign ref_pins = '{ref_single_first: div_r[2], ref_single_second: div_r[3],
                       ref_diff_pos: div_r[2], ref_diff_neg: ~div_r[2]};
   assign vco_clk = div_r[0];
   // Slow loop settles seven cycles after the fast one but loses lock at once
   assign phase_freq_compare = slow ? (lag_r[7] & lag_r[0]) : lag_r[0];
endmodule // ref_src_model

// [dv/pll_divider_refselect_lock_tb.sv]
// Self-checking bench for the clock control block.
// Assumes the far-side model and the bound checker are compiled first.
`timescale 1ns/1ps
module pll_divider_refselect_lock_tb;
   import pll_ctrl_pkg::*;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, d;
   logic        ref_input_choose, bypass_pin, vco_clk, phase_freq_compare;
   logic        fb_to_compare, lock, irq, in_lock_req, slow;
   logic [3:0]  clk_out;
   logic [4:0]  mon;
   logic [7:0]  ref_hist;
   ref_pins_t   ref_pins;
   int          errors, comparisons;

   assign mon = {fb_to_compare, clk_out};
   always @(posedge pclk) ref_hist <= {ref_hist[6:0], ref_pins.ref_single_first};
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end

   pll_divider_refselect_lock #(.N_OUT(4)) dut_u (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .ref_pins(ref_pins), .ref_input_choose(ref_input_choose), .bypass_pin(bypass_pin),
      .vco_clk(vco_clk), .phase_freq_compare(phase_freq_compare), .ext_fb_in(clk_out[3]),
      .fb_to_compare(fb_to_compare), .lock(lock), .clk_out(clk_out), .irq(irq));
   ref_src_model far_u (.pclk(pclk), .presetn(presetn), .in_lock_req(in_lock_req),
      .slow(slow), .ref_pins(ref_pins), .vco_clk(vco_clk),
      .phase_freq_compare(phase_freq_compare));

   // ------
   // Shared tasks
   // ------
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      d = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      check(d, exp);
   endtask
   task automatic rise(input int i, inout int t);
      while (mon[i] !== 1'b0 && t < 1200) begin
         @(posedge pclk);
         t++;
      end
      while (mon[i] !== 1'b1 && t < 1200) begin
         @(posedge pclk);
         t++;
      end
   endtask
   // First whole period may straddle a setting change, so skip it
   task automatic per(input int i, input int exp);
      int t;
      t = 0;
      rise(i, t);
      rise(i, t);
      t = 0;
      rise(i, t);
      check(t, exp);
   endtask
   task automatic wait_lock(input logic v, output int t);
      t = 0;
      while (lock !== v && t < 3000) begin
         @(posedge pclk);
         t++;
      end
   endtask
   task automatic stop_test;
      $display("comparisons %0d errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // ------
   // Scenarios
   // ------
   task automatic t_regs;
      rdchk(OFF_CTRL, CTRL_RST);
      rdchk(OFF_DIVSET, DIVSET_RST);
      rdchk(OFF_LOCKCNT, {23'h0, LOCKCNT_RST});
      apb(1'b1, OFF_LOCKCNT, 32'h0000_0008);
      rdchk(OFF_LOCKCNT, {23'h0, LOCKCNT_MIN});
      apb(1'b1, OFF_LOCKCNT, 32'h0000_01FF);
      rdchk(OFF_LOCKCNT, {23'h0, LOCKCNT_MAX});
      apb(1'b1, OFF_DIVSET, 32'h0004_0201);
      apb(1'b1, OFF_DIVSET, 32'h0004_0203);
      rdchk(OFF_DIVSET, 32'h0004_0201);
      apb(1'b0, 8'h40, 32'h0);
      check(e, 1'b1);
   endtask
   task automatic t_bypass;
      int k;
      logic [2:0] ok;
      bypass_pin <= 1'b1;
      apb(1'b1, OFF_ROUTE, 32'h0000_2310);
      for (k = 1; k <= 32; k = k * 2) begin
         apb(1'b1, OFF_DIVSET, 32'h0004_0001 | (k << 8));
         per(1, 8 * k);
      end
      per(3, 32);
      ok = 3'b111;
      repeat (32) begin
         @(posedge pclk);
         for (k = 0; k < 3; k++) if (clk_out[0] !== ~ref_hist[k + 2]) ok[k] = 1'b0;
      end
      check(ok != 3'b000, 1'b1);
      rdchk(OFF_STATUS, 32'h0000_0008);
   endtask
   task automatic t_ref_input_choose;
      int t;
      apb(1'b1, OFF_DIVSET, 32'h0004_0101);
      per(2, 8);
      ref_input_choose <= 1'b1;
      per(2, 16);
      ref_input_choose <= 1'b0;
      apb(1'b1, OFF_CTRL, 32'h0000_0001);
      repeat (8) @(posedge pclk);
      t = 0;
      repeat (40) begin
         @(posedge pclk);
         if (clk_out[2] !== 1'b0) t++;
      end
      check(t, 0);
      per(1, 8);
      apb(1'b1, OFF_CTRL, 32'h0);
   endtask
   task automatic t_fb;
      bypass_pin <= 1'b0;
      apb(1'b1, OFF_CTRL, 32'h0000_0020);
      per(4, 8);
      per(3, 8);
      apb(1'b1, OFF_ROUTE, 32'h0000_1310);
      apb(1'b1, OFF_CTRL, 32'h0000_0022);
      per(4, 2);
      apb(1'b1, OFF_CTRL, 32'h0);
   endtask
   // Equal dividers, one skewed: offset is two cycles per oscillator step
   task automatic t_skew;
      int t;
      apb(1'b1, OFF_DIVSET, 32'h0004_0404);
      apb(1'b1, OFF_ROUTE, 32'h0000_1410);
      apb(1'b1, OFF_SKEW, 32'h0000_0030);
      per(4, 8);
      per(2, 16);
      t = 0;
      rise(0, t);
      t = 0;
      rise(1, t);
      check(t, 6);
      bypass_pin <= 1'b1;
      per(0, 32);
      t = 0;
      rise(0, t);
      t = 0;
      rise(1, t);
      check(t, 32);
      bypass_pin <= 1'b0;
      apb(1'b1, OFF_SKEW, 32'h0);
   endtask
   task automatic t_lock(input int cnt, input logic slw, input logic via_byp);
      int t;
      slow <= slw;
      apb(1'b1, OFF_LOCKCNT, cnt);
      apb(1'b1, OFF_IRQ_MSK, 32'h0000_0003);
      apb(1'b1, OFF_IRQ_ST, 32'h0000_0003);
      in_lock_req <= 1'b1;
      wait_lock(1'b1, t);
      check(t >= 8 * cnt - 8 && t <= 8 * cnt + 32, 1'b1);
      @(posedge pclk);
      check(irq, 1'b1);
      rdchk(OFF_IRQ_ST, 32'h0000_0001);
      apb(1'b1, OFF_IRQ_ST, 32'h0000_0001);
      check(irq, 1'b0);
      if (via_byp)
         bypass_pin <= 1'b1;
      else
         in_lock_req <= 1'b0;
      wait_lock(1'b0, t);
      check(t <= 6, 1'b1);
      @(posedge pclk);
      check(irq, 1'b1);
      if (via_byp) begin
         bypass_pin <= 1'b0;
         wait_lock(1'b1, t);
         check(t >= 8 * cnt - 8, 1'b1);
         in_lock_req <= 1'b0;
      end
      repeat (12) @(posedge pclk);
      apb(1'b1, OFF_IRQ_MSK, 32'h0);
      check(irq, 1'b0);
      apb(1'b1, OFF_IRQ_ST, 32'h0000_0003);
   endtask

   initial begin
      errors = 0;
      comparisons = 0;
      {psel, penable, pwrite, paddr, pwdata} = '0;
      {ref_input_choose, bypass_pin, in_lock_req, slow} = 4'h0;
      presetn = 1'b0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_regs;
      t_bypass;
      t_ref_input_choose;
      t_fb;
      t_skew;
      t_lock(16, 1'b0, 1'b0);
      t_lock(256, 1'b1, 1'b1);
      t_lock(32, 1'b0, 1'b1);
      stop_test;
   end
   initial begin
      repeat (40000) @(posedge pclk);
      errors++;
      stop_test;
   end
endmodule // pll_divider_refselect_lock_tb
